// ### dsp_regs.sv
// dual slot power control and status register bank
// Summary of operation
// - slot A control: bit1 primary enable, bit0 aux enable, bits5..2 read zero.
// - slot A control bits 7/6 read aux and primary power good, read-only.
// - slot A control resets to 00h, all slot A outputs off.
// - slot B control: bit1 primary enable, bit0 aux enable, bits5..2 read zero.
// - slot B control bits 7/6 read aux and primary power good, read-only.
// - slot B control resets to 00h, all slot B outputs off.
// - slot A status bit7 mirrors the slot A fault pin state.
// - slot A status bit6 shows actual primary output on state.
// - slot A status bit5 shows actual aux output on state.
// - slot A status bits4..0 are aux, -12V, +12V, 5V, 3V overcurrent flags.
// - writing 1 clears a set flag; interrupt releases once no flag of either slot is set; 0 leaves it.
// - reading a status register has no side effect on the fault pin.
// - slot A status resets to 00h and sits at command 04h.
// - slot B status uses the same layout as slot A.
// - fault bits and pin inactive while a slot is under register control.
// - access only by byte read and byte write with a command byte.
`timescale 1ns/10ps
`include "dsp_map.svh"
module dsp_regs
  import dsp_pkg::*;
#(
  parameter int OC_W = `DSP_OC_W
) (
  input  wire logic            ref_clk_i,
  input  wire logic            rst_i,
  input  wire logic            wr_stb_i,
  input  wire logic            rd_stb_i,
  input  wire logic [7:0]      cmd_i,
  input  wire logic [7:0]      wr_data_i,
  output logic      [7:0]      rd_data_o,
  output logic                 rd_valid_o,
  input  wire logic [1:0]      aux_power_good_i,
  input  wire logic [1:0]      primary_power_good_i,
  input  wire logic [1:0]      primary_on_i,
  input  wire logic [1:0]      aux_on_i,
  input  wire logic [1:0]      on_pin_i,
  input  wire logic [1:0]      slot_aux_on_pin_i,
  input  wire logic [1:0]      fault_pin_state_i,
  input  wire logic [OC_W-1:0] slot_a_oc_event_i,
  input  wire logic [OC_W-1:0] slot_b_oc_event_i,
  output logic                 slot_a_primary_enable_o,
  output logic                 slot_a_aux_enable_o,
  output logic                 slot_b_primary_enable_o,
  output logic                 slot_b_aux_enable_o,
  output logic                 slot_a_fault_n_o,
  output logic                 slot_b_fault_n_o,
  output logic                 int_n_o
);
  logic [1:0]      en_pri_r;
  logic [1:0]      en_aux_r;
  logic [OC_W-1:0] oc_a_r;
  logic [OC_W-1:0] oc_b_r;
  logic [OC_W-1:0] oc_a_nxt;
  logic [OC_W-1:0] oc_b_nxt;
  logic [OC_W-1:0] ev_a_s;
  logic [OC_W-1:0] ev_b_s;
  logic [OC_W-1:0] ev_a_d_r;
  logic [OC_W-1:0] ev_b_d_r;
  dsp_byte_t       rd_data_nxt;
  logic [1:0]      apg_s;
  logic [1:0]      ppg_s;
  logic [1:0]      pon_s;
  logic [1:0]      aon_s;
  logic [1:0]      onp_s;
  logic [1:0]      auxp_s;
  logic [1:0]      flt_s;
  logic [1:0]      reg_ctrl;
  logic            wr_a_stat;
  logic            wr_b_stat;

  initial begin
    if (OC_W != `DSP_OC_W) $error("dsp_regs supports exactly five overcurrent flags per slot");
    if (`DSP_OFS_STAT_A == `DSP_OFS_STAT_B) $error("dsp_regs status offsets collide");
    if (`DSP_OFS_CTRL_A == `DSP_OFS_CTRL_B) $error("dsp_regs control offsets collide");
  end

  // one synchroniser per pin group keeps each group's flops easy to find
  dsp_sync #(.W(2)) u_apg_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (aux_power_good_i),
    .sync_o    (apg_s)
  );

  dsp_sync #(.W(2)) u_ppg_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (primary_power_good_i),
    .sync_o    (ppg_s)
  );

  dsp_sync #(.W(2)) u_pon_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (primary_on_i),
    .sync_o    (pon_s)
  );

  dsp_sync #(.W(2)) u_aon_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (aux_on_i),
    .sync_o    (aon_s)
  );

  dsp_sync #(.W(2)) u_onp_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (on_pin_i),
    .sync_o    (onp_s)
  );

  dsp_sync #(.W(2)) u_auxp_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (slot_aux_on_pin_i),
    .sync_o    (auxp_s)
  );

  dsp_sync #(.W(2)) u_flt_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (fault_pin_state_i),
    .sync_o    (flt_s)
  );

  dsp_sync #(.W(OC_W)) u_eva_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (slot_a_oc_event_i),
    .sync_o    (ev_a_s)
  );

  dsp_sync #(.W(OC_W)) u_evb_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   (slot_b_oc_event_i),
    .sync_o    (ev_b_s)
  );

  // a slot counts as register controlled while both of its hot-plug pins are low
  assign reg_ctrl = ~(onp_s | auxp_s);

  function automatic dsp_oc_t oc_next(input dsp_oc_t cur, input dsp_oc_t rise,
                                      input logic wr, input dsp_oc_t clr);
    dsp_oc_t kept;
    kept = wr ? (cur & ~clr) : cur;
    // a new event in the clearing cycle wins over the clear
    return kept | rise;
  endfunction

  function automatic dsp_byte_t stat_byte(input logic flt, input logic pon, input logic aon,
                                          input dsp_oc_t oc, input logic rc);
    return {flt & ~rc, pon, aon, oc};
  endfunction

  function automatic dsp_byte_t ctrl_byte(input logic apg, input logic ppg, input logic pen, input logic aen);
    return {apg, ppg, 4'h0, pen, aen};
  endfunction

  // control enables, reset off
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      en_pri_r <= 2'b00;
      en_aux_r <= 2'b00;
    end else if (wr_stb_i) begin
      if (cmd_i == `DSP_OFS_CTRL_A) begin
        en_pri_r[DSP_SLOT_A] <= wr_data_i[`DSP_CTRL_PRI_EN];
        en_aux_r[DSP_SLOT_A] <= wr_data_i[`DSP_CTRL_AUX_EN];
      end else if (cmd_i == `DSP_OFS_CTRL_B) begin
        en_pri_r[DSP_SLOT_B] <= wr_data_i[`DSP_CTRL_PRI_EN];
        en_aux_r[DSP_SLOT_B] <= wr_data_i[`DSP_CTRL_AUX_EN];
      end
    end
  end

  // status bits 7..5 ignore writes; only the flag field takes a clear
  assign wr_a_stat = wr_stb_i && (cmd_i == `DSP_OFS_STAT_A);
  assign wr_b_stat = wr_stb_i && (cmd_i == `DSP_OFS_STAT_B);

  // flags latch on a rising event so a held condition does not refire after clear
  always_comb begin
    oc_a_nxt = oc_next(oc_a_r, ev_a_s & ~ev_a_d_r, wr_a_stat, wr_data_i[OC_W-1:0]);
    if (reg_ctrl[DSP_SLOT_A]) begin
      oc_a_nxt = '0;
    end
  end

  always_comb begin
    oc_b_nxt = oc_next(oc_b_r, ev_b_s & ~ev_b_d_r, wr_b_stat, wr_data_i[OC_W-1:0]);
    if (reg_ctrl[DSP_SLOT_B]) begin
      oc_b_nxt = '0;
    end
  end

  // slot A flags and their rise detector
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      oc_a_r   <= '0;
      ev_a_d_r <= '0;
    end else begin
      oc_a_r   <= oc_a_nxt;
      ev_a_d_r <= ev_a_s;
    end
  end

  // slot B flags and their rise detector
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      oc_b_r   <= '0;
      ev_b_d_r <= '0;
    end else begin
      oc_b_r   <= oc_b_nxt;
      ev_b_d_r <= ev_b_s;
    end
  end

  // read decode; reads have no side effects on any state
  always_comb begin
    // unmapped commands read zero
    rd_data_nxt = `DSP_UNMAPPED_READ;
    if (cmd_i == `DSP_OFS_CTRL_A) begin
      rd_data_nxt = ctrl_byte(apg_s[DSP_SLOT_A], ppg_s[DSP_SLOT_A],
                              en_pri_r[DSP_SLOT_A], en_aux_r[DSP_SLOT_A]);
    end else if (cmd_i == `DSP_OFS_CTRL_B) begin
      rd_data_nxt = ctrl_byte(apg_s[DSP_SLOT_B], ppg_s[DSP_SLOT_B],
                              en_pri_r[DSP_SLOT_B], en_aux_r[DSP_SLOT_B]);
    end else if (cmd_i == `DSP_OFS_STAT_A) begin
      rd_data_nxt = stat_byte(flt_s[DSP_SLOT_A], pon_s[DSP_SLOT_A], aon_s[DSP_SLOT_A],
                              oc_a_r, reg_ctrl[DSP_SLOT_A]);
    end else if (cmd_i == `DSP_OFS_STAT_B) begin
      rd_data_nxt = stat_byte(flt_s[DSP_SLOT_B], pon_s[DSP_SLOT_B], aon_s[DSP_SLOT_B],
                              oc_b_r, reg_ctrl[DSP_SLOT_B]);
    end
  end

  // data holds between reads so a slow host can fetch it late
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_stb_i;
      if (rd_stb_i) begin
        rd_data_o <= rd_data_nxt;
      end
    end
  end

  // slot A enable pins follow the control bits one edge later
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot_a_primary_enable_o <= 1'b0;
      slot_a_aux_enable_o     <= 1'b0;
    end else begin
      slot_a_primary_enable_o <= en_pri_r[DSP_SLOT_A];
      slot_a_aux_enable_o     <= en_aux_r[DSP_SLOT_A];
    end
  end

  // slot B enable pins
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot_b_primary_enable_o <= 1'b0;
      slot_b_aux_enable_o     <= 1'b0;
    end else begin
      slot_b_primary_enable_o <= en_pri_r[DSP_SLOT_B];
      slot_b_aux_enable_o     <= en_aux_r[DSP_SLOT_B];
    end
  end

  // fault pin held until host writes 1 to every set flag of the slot or drops both pins of the slot
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot_a_fault_n_o <= 1'b1;
    end else begin
      slot_a_fault_n_o <= ~(|oc_a_nxt);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot_b_fault_n_o <= 1'b1;
    end else begin
      slot_b_fault_n_o <= ~(|oc_b_nxt);
    end
  end

  // interrupt taken from the next flag values so it moves with the flags
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= ~(|oc_a_nxt | |oc_b_nxt);
    end
  end
endmodule

// ### dsp_map.svh
// register offsets, field positions and reset values for the slot power register bank
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH
`define DSP_OFS_CTRL_A     8'h02
`define DSP_OFS_CTRL_B     8'h03
`define DSP_OFS_STAT_A     8'h04
`define DSP_OFS_STAT_B     8'h05
`define DSP_CTRL_RST       8'h00
`define DSP_STAT_RST       8'h00
`define DSP_CTRL_AUX_PG    7
`define DSP_CTRL_PRI_PG    6
`define DSP_CTRL_PRI_EN    1
`define DSP_CTRL_AUX_EN    0
`define DSP_STAT_FAULT     7
`define DSP_STAT_PRI_ON    6
`define DSP_STAT_AUX_ON    5
`define DSP_OC_AUX         4
`define DSP_OC_NEG12       3
`define DSP_OC_POS12       2
`define DSP_OC_FIVE        1
`define DSP_OC_THREE       0
`define DSP_OC_W           5
`define DSP_UNMAPPED_READ  8'h00
`endif

// ### dsp_pkg.sv
// types shared by the slot power register bank
package dsp_pkg;
  typedef logic [7:0] dsp_byte_t;
  typedef logic [4:0] dsp_oc_t;
  typedef enum logic {DSP_SLOT_A, DSP_SLOT_B} dsp_slot_t;
endpackage

// ### dsp_sync.sv
// two flip-flop synchroniser for a bank of pin levels
`timescale 1ns/10ps
module dsp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  initial begin
    if (W < 1) $error("dsp_sync width must be at least 1");
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// ### dsp_regs_props.sv
// concurrent checks on the slot power register bank ports
`timescale 1ns/10ps
module dsp_regs_props (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       wr_stb_i,
  input wire logic       rd_stb_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic       rd_valid_o,
  input wire logic       slot_a_primary_enable_o,
  input wire logic       slot_a_aux_enable_o,
  input wire logic       slot_b_primary_enable_o,
  input wire logic       slot_b_aux_enable_o,
  input wire logic       slot_a_fault_n_o,
  input wire logic       slot_b_fault_n_o,
  input wire logic       int_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  rd_answer_a: assert property (rd_stb_i |=> rd_valid_o) else $error("read not answered");
  rd_cause_a: assert property (rd_valid_o |-> $past(rd_stb_i)) else $error("stray read valid");
  rd_hold_a: assert property (!$past(rd_stb_i) |-> $stable(rd_data_o)) else $error("read data moved");
  ctrl_a_en_a: assert property (wr_stb_i && cmd_i == 8'h02 |=> ##1
    {6'h00, slot_a_primary_enable_o, slot_a_aux_enable_o} == ($past(wr_data_i, 2) & 8'h03)) else $error("slot a enables");
  ctrl_b_en_a: assert property (wr_stb_i && cmd_i == 8'h03 |=> ##1
    {6'h00, slot_b_primary_enable_o, slot_b_aux_enable_o} == ($past(wr_data_i, 2) & 8'h03)) else $error("slot b enables");
  rsvd_zero_a: assert property (rd_valid_o && $past(cmd_i) inside {8'h02, 8'h03} |-> rd_data_o[5:2] == 4'h0)
    else $error("reserved bits set");
  unmapped_a: assert property (rd_valid_o && ($past(cmd_i) < 8'h02 || $past(cmd_i) > 8'h05) |-> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  int_join_a: assert property (int_n_o == (slot_a_fault_n_o && slot_b_fault_n_o)) else $error("int mismatch");
  reset_idle_a: assert property ($past(rst_i) |-> int_n_o && !slot_a_primary_enable_o && !slot_b_aux_enable_o)
    else $error("not idle after reset");
  cover property (wr_stb_i && cmd_i == 8'h04);
  cover property ($fell(int_n_o));
  cover property (rd_valid_o && rd_data_o[4:0] != 5'h00);
endmodule
bind dsp_regs dsp_regs_props dsp_regs_props_i (.*);

// ### dsp_host.sv
// host model issuing single byte reads and writes
`timescale 1ns/10ps
module dsp_host (
  input  wire logic       ref_clk_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_stb_o = 1'b0,
  output logic            rd_stb_o = 1'b0,
  output logic      [7:0] cmd_o = 8'h00,
  output logic      [7:0] wr_data_o = 8'h00
);
  // command byte and one data byte together per transfer
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge ref_clk_i);
    {wr_stb_o, cmd_o, wr_data_o} = {1'b1, c, d};
    @(negedge ref_clk_i);
    {wr_stb_o, cmd_o, wr_data_o} = {1'b0, ~c, ~d};
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(negedge ref_clk_i);
    {rd_stb_o, cmd_o} = {1'b1, c};
    @(negedge ref_clk_i);
    {rd_stb_o, cmd_o} = {1'b0, ~c};
    d = rd_valid_i ? rd_data_i : 8'hxx;
  endtask
endmodule

// ### test_dsp_regs.sv
// self-checking bench for the slot power register bank
`timescale 1ns/10ps
module test_dsp_regs;
  import dsp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_stb, rd_stb, rd_valid, int_n;
  logic [7:0] cmd, wdata, rdata;
  logic [1:0] apg = 2'b00, ppg = 2'b00, pon = 2'b00, aon = 2'b00, onp = 2'b00, axp = 2'b00, fpin = 2'b00;
  logic [1:0] pen, aen, fn;
  logic [4:0] oca = 5'h00, ocb = 5'h00;
  int fail_count = 0;
  int compares = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  dsp_host dsp_host_i (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid), .rd_data_i(rdata), .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb), .cmd_o(cmd), .wr_data_o(wdata));
  dsp_regs dsp_regs_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .cmd_i(cmd),
    .wr_data_i(wdata), .rd_data_o(rdata), .rd_valid_o(rd_valid), .aux_power_good_i(apg), .primary_power_good_i(ppg),
    .primary_on_i(pon), .aux_on_i(aon), .on_pin_i(onp), .slot_aux_on_pin_i(axp), .fault_pin_state_i(fpin),
    .slot_a_oc_event_i(oca), .slot_b_oc_event_i(ocb), .slot_a_primary_enable_o(pen[0]), .slot_a_aux_enable_o(aen[0]),
    .slot_b_primary_enable_o(pen[1]), .slot_b_aux_enable_o(aen[1]), .slot_a_fault_n_o(fn[0]),
    .slot_b_fault_n_o(fn[1]), .int_n_o(int_n));
  task automatic chk(input dsp_byte_t got, input dsp_byte_t exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input dsp_byte_t c, input dsp_byte_t exp);
    dsp_byte_t d;
    dsp_host_i.rd(c, d);
    chk(d, exp);
  endtask
  task automatic t_reset();
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, 8'h00);
    rdchk(8'h04, 8'h00);
    rdchk(8'h07, 8'h00);
  endtask
  task automatic t_ctrl();
    apg = 2'b01;
    ppg = 2'b10;
    dsp_host_i.wr(8'h02, 8'hff);
    dsp_host_i.wr(8'h03, 8'hfe);
    rdchk(8'h02, 8'h83);
    rdchk(8'h03, 8'h42);
    chk({4'h0, pen, aen}, 8'h0d);
  endtask
  task automatic t_fault_a();
    {onp, axp, pon, aon, fpin} = {2'b11, 2'b11, 2'b01, 2'b01, 2'b01};
    repeat (4) @(negedge ref_clk_i);
    oca = 5'h04;
    repeat (6) @(negedge ref_clk_i);
    chk({6'h00, int_n, fn[0]}, 8'h00);
    rdchk(8'h04, 8'he4);
    rdchk(8'h04, 8'he4);
    dsp_host_i.wr(8'h04, 8'h1b);
    rdchk(8'h04, 8'he4);
    dsp_host_i.wr(8'h04, 8'h04);
    chk({6'h00, int_n, fn[0]}, 8'h03);
    rdchk(8'h04, 8'he0);
  endtask
  task automatic t_fault_b();
    oca = 5'h00;
    ocb = 5'h10;
    repeat (6) @(negedge ref_clk_i);
    chk({5'h00, int_n, fn}, 8'h01);
    rdchk(8'h05, 8'h10);
    dsp_host_i.wr(8'h05, 8'h10);
    chk({5'h00, int_n, fn}, 8'h07);
  endtask
  task automatic t_regmode();
    // host drops both pins, slot falls under register control
    {onp, axp, ocb} = {2'b00, 2'b00, 5'h00};
    repeat (4) @(negedge ref_clk_i);
    oca = 5'h1f;
    repeat (6) @(negedge ref_clk_i);
    chk({5'h00, int_n, fn}, 8'h07);
    rdchk(8'h04, 8'h60);
  endtask
  task automatic conclude();
    $display("fail_count %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_ctrl();
    t_fault_a();
    t_fault_b();
    t_regmode();
    conclude();
  end
  // whole run needs about sixty cycles
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    fail_count++;
    conclude();
  end
endmodule
